// *** hw/linear_range_check.v ***
// Range check of a linear-format word against a fixed exponent and mantissa span
module linear_range_check (
    input  wire [15:0] word_in,
    input  wire [4:0]  exp_in,
    input  wire [10:0] min_in,
    input  wire [10:0] max_in,
    output wire        ok_out
);
    assign ok_out = (word_in[15:11] == exp_in) && (word_in[10:0] >= min_in)
                    && (word_in[10:0] <= max_in);
endmodule // linear_range_check

// *** hw/pmbus_cmd_defs.vh ***
// Command codes, field positions, reset values and linear-format constants
`ifndef PMBUS_CMD_DEFS_VH
`define PMBUS_CMD_DEFS_VH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define CMD_OUTPUT_ENABLE       8'h01
`define CMD_CLEAR_FAULTS        8'h03
`define CMD_TEMP_FAULT_THR      8'h4F
`define CMD_TEMP_WARN_THR       8'h51
`define CMD_VIN_OV_FAULT_THR    8'h55
`define CMD_GOOD_ASSERT         8'h5E
`define CMD_GOOD_NEGATE         8'h5F
`define CMD_TURN_ON_DELAY       8'h60
`define CMD_RISE_TIME           8'h61
`define CMD_SUMMARY_WORD        8'h79
`define CMD_OUTVOLT_BYTE        8'h7A
`define CMD_OUTCURR_BYTE        8'h7B
`define CMD_INPUT_BYTE          8'h7C
`define CMD_THERMAL_BYTE        8'h7D
`define CMD_COMMS_BYTE          8'h7E
`define CMD_MEAS_VIN            8'h88
`define CMD_MEAS_VOUT           8'h8B
`define CMD_MEAS_IOUT           8'h8C
`define CMD_HOTSPOT_TEMP        8'h8D
`define CMD_PROTOCOL_REV        8'h98
`define CMD_UNLOCK_KEY          8'hEC

// ----------------------------------------------------------------------------
// Linear-format words: exponent in bits 15:11, mantissa in bits 10:0
// ----------------------------------------------------------------------------
`define EXP_TEMP                5'h1E
`define EXP_VIN                 5'h1D
`define EXP_TIME                5'h1F
`define MANT_TEMP_WARN_DEF      11'h190
`define MANT_TEMP_WARN_MAX      11'h1E0
`define MANT_TEMP_FAULT         11'h21C
`define MANT_VIN_OV             11'h1F0
`define MANT_DELAY_DEF          11'h02C
`define MANT_DELAY_MAX          11'h0A4
`define MANT_RISE               11'h014
// Output voltage words are plain mantissa with exponent -12
`define VOUT_GOOD_ON            16'hB666
`define VOUT_GOOD_OFF           16'hB333

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define OUTPUT_ENABLE_RST       8'h80
`define OUTPUT_ENABLE_BIT       7
`define UNLOCK_KEY_RST          32'hA5A5_A5A5
`define UNLOCK_KEY_MATCH        32'h7E15_DC42
`define WORD_PG_BIT             11
`define WORD_VOUT_BIT           15
`define WORD_IOUT_BIT           14
`define WORD_INPUT_BIT          13
`define WORD_OFF_BIT            6
`define WORD_VOUT_OV_BIT        5
`define WORD_IOUT_OC_BIT        4
`define WORD_VIN_UV_BIT         3
`define WORD_TEMP_BIT           2
`define WORD_CML_BIT            1
`define CML_BAD_CMD_BIT         7
`define CML_BAD_DATA_BIT        6

`endif

// *** hw/power_good_detect.v ***
// Power-good comparator with hysteresis on the output voltage word
`include "pmbus_cmd_defs.vh"
module power_good_detect (
    input  wire        core_clk_in,
    input  wire        arst_n_in,
    input  wire [15:0] vout_in,
    output reg         good_out
);
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            good_out <= 1'b0;
        end else if (vout_in >= `VOUT_GOOD_ON) begin
            good_out <= 1'b1;
        end else if (vout_in <= `VOUT_GOOD_OFF) begin
            good_out <= 1'b0;
        end
    end
endmodule // power_good_detect

// *** hw/power_module_cmd_regs.v ***
// Command register bank of the power module management interface
//
// How it works
// - Temperature warning threshold, read/write, exponent -2, default 100, range 100..120.
// - Input overvoltage fault threshold reads 62 V, exponent -3, read-only.
// - Power-good flag asserts once output voltage reaches the on level 11.4 V.
// - Power-good flag negates when output falls to the off level 11.2 V.
// - Turn-on delay, read/write, exponent -1, default 22 ms, range 22..82.
// - Output rise time reads 10 ms with exponent -1, read-only.
// - Summary status word returned on a word read.
// - Output voltage status byte returned on a byte read.
// - Output current status byte returned on a byte read.
// - Input over/undervoltage status byte returned on a byte read.
// - Temperature status byte returned on a byte read.
// - Measured input voltage returned, exponent -3.
// - Measured output voltage returned, exponent -12.
// - Measured output current returned, exponent -3.
// - Hot-spot temperature returned, exponent -2.
// - Fixed protocol revision byte returned.
// - Flash unlocks only when the written four-byte key block matches.
// - Clear command send-byte clears all latched fault bits, except a fault present in the clear cycle, which stays latched.
`include "pmbus_cmd_defs.vh"
module power_module_cmd_regs #(
    parameter [7:0] PROTOCOL_REV = 8'h11 // arbitrary value
) (
    input  wire        core_clk_in,
    input  wire        arst_n_in,
    input  wire        cmd_valid_in,
    input  wire        cmd_write_in,
    input  wire [7:0]  cmd_code_in,
    input  wire [2:0]  cmd_len_in,
    input  wire [31:0] cmd_wdata_in,
    output reg  [31:0] cmd_rdata_out,
    output reg  [2:0]  cmd_rlen_out,
    output reg         cmd_done_out,
    input  wire [15:0] meas_vin_in,
    input  wire [15:0] meas_vout_in,
    input  wire [15:0] meas_iout_in,
    input  wire [15:0] meas_temp_in,
    input  wire        out_on_in,
    input  wire        vout_ov_fault_in,
    input  wire        vout_ov_warn_in,
    input  wire        iout_oc_fault_in,
    input  wire        iout_oc_warn_in,
    input  wire        vin_ov_fault_in,
    input  wire        vin_uv_fault_in,
    input  wire        temp_fault_in,
    input  wire        temp_warn_in,
    output wire        output_enable_out,
    output wire        flash_unlocked_out,
    output wire [15:0] temp_warn_threshold_out,
    output wire [15:0] turn_on_delay_time_out,
    output wire        power_good_out
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg  [7:0]  output_enable_command;
    reg  [15:0] temp_warn_threshold;
    reg  [15:0] turn_on_delay_time;
    reg  [31:0] nonvolatile_unlock_key;
    reg  [7:0]  outvolt_fault_byte;
    reg  [7:0]  outcurr_fault_byte;
    reg  [7:0]  input_fault_byte;
    reg  [7:0]  thermal_fault_byte;
    reg  [7:0]  comms_fault_byte;
    wire        good;
    wire        warn_ok;
    wire        delay_ok;

    function [15:0] lin;
        input [4:0]  e;
        input [10:0] m;
        begin
            lin = {e, m};
        end
    endfunction

    function is_writable;
        input [7:0] c;
        begin
            is_writable = (c == `CMD_OUTPUT_ENABLE) || (c == `CMD_TEMP_WARN_THR)
                || (c == `CMD_TURN_ON_DELAY) || (c == `CMD_UNLOCK_KEY)
                || (c == `CMD_CLEAR_FAULTS);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    power_good_detect u_pg (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .vout_in     (meas_vout_in),
        .good_out    (good)
    );

    linear_range_check u_warn_chk (
        .word_in (cmd_wdata_in[15:0]),
        .exp_in  (`EXP_TEMP),
        .min_in  (`MANT_TEMP_WARN_DEF),
        .max_in  (`MANT_TEMP_WARN_MAX),
        .ok_out  (warn_ok)
    );

    linear_range_check u_delay_chk (
        .word_in (cmd_wdata_in[15:0]),
        .exp_in  (`EXP_TIME),
        .min_in  (`MANT_DELAY_DEF),
        .max_in  (`MANT_DELAY_MAX),
        .ok_out  (delay_ok)
    );

    // ------------------------------------------------------------------------
    // Writes, latched faults
    // ------------------------------------------------------------------------
    wire wr       = cmd_valid_in && cmd_write_in;
    wire clr      = wr && (cmd_code_in == `CMD_CLEAR_FAULTS);
    wire bad_cmd  = wr && !is_writable(cmd_code_in);
    wire bad_data = wr && (((cmd_code_in == `CMD_TEMP_WARN_THR) && !warn_ok)
                    || ((cmd_code_in == `CMD_TURN_ON_DELAY) && !delay_ok));

    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            output_enable_command  <= `OUTPUT_ENABLE_RST;
            temp_warn_threshold    <= {`EXP_TEMP, `MANT_TEMP_WARN_DEF};
            turn_on_delay_time     <= {`EXP_TIME, `MANT_DELAY_DEF};
            nonvolatile_unlock_key <= `UNLOCK_KEY_RST;
        end else if (wr) begin
            case (cmd_code_in)
                `CMD_OUTPUT_ENABLE: begin
                    output_enable_command <= {cmd_wdata_in[`OUTPUT_ENABLE_BIT], 7'h00};
                end
                `CMD_TEMP_WARN_THR: begin
                    if (warn_ok) temp_warn_threshold <= cmd_wdata_in[15:0];
                end
                `CMD_TURN_ON_DELAY: begin
                    if (delay_ok) turn_on_delay_time <= cmd_wdata_in[15:0];
                end
                `CMD_UNLOCK_KEY: begin
                    nonvolatile_unlock_key <= cmd_wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    // Set wins over clear: a fault present in the clear cycle stays latched
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            outvolt_fault_byte <= 8'h00;
            outcurr_fault_byte <= 8'h00;
            input_fault_byte   <= 8'h00;
            thermal_fault_byte <= 8'h00;
            comms_fault_byte   <= 8'h00;
        end else begin
            outvolt_fault_byte <= (clr ? 8'h00 : outvolt_fault_byte)
                | {vout_ov_fault_in, vout_ov_warn_in, 6'h00};
            outcurr_fault_byte <= (clr ? 8'h00 : outcurr_fault_byte)
                | {iout_oc_fault_in, 1'b0, iout_oc_warn_in, 5'h00};
            input_fault_byte   <= (clr ? 8'h00 : input_fault_byte)
                | {vin_ov_fault_in, 2'b00, vin_uv_fault_in, 4'h0};
            thermal_fault_byte <= (clr ? 8'h00 : thermal_fault_byte)
                | {temp_fault_in, temp_warn_in, 6'h00};
            comms_fault_byte   <= (clr ? 8'h00 : comms_fault_byte)
                | {bad_cmd, bad_data, 6'h00};
        end
    end

    // ------------------------------------------------------------------------
    // Summary word
    // ------------------------------------------------------------------------
    reg [15:0] summary;
    always @* begin
        summary = 16'h0000;
        summary[`WORD_VOUT_BIT]    = |outvolt_fault_byte;
        summary[`WORD_IOUT_BIT]    = |outcurr_fault_byte;
        summary[`WORD_INPUT_BIT]   = |input_fault_byte;
        summary[`WORD_PG_BIT]      = !good;
        summary[`WORD_OFF_BIT]     = !out_on_in;
        summary[`WORD_VOUT_OV_BIT] = outvolt_fault_byte[7];
        summary[`WORD_IOUT_OC_BIT] = outcurr_fault_byte[7];
        summary[`WORD_VIN_UV_BIT]  = input_fault_byte[4];
        summary[`WORD_TEMP_BIT]    = |thermal_fault_byte;
        summary[`WORD_CML_BIT]     = |comms_fault_byte;
    end

    // ------------------------------------------------------------------------
    // Read answer, registered one cycle after the request
    // ------------------------------------------------------------------------
    reg [31:0] next_rdata;
    reg [2:0]  next_rlen;
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rlen  = 3'h2;
        case (cmd_code_in)
            `CMD_OUTPUT_ENABLE:    begin next_rdata[7:0] = output_enable_command; next_rlen = 3'h1; end
            `CMD_TEMP_WARN_THR:    next_rdata[15:0] = temp_warn_threshold;
            `CMD_TEMP_FAULT_THR:   next_rdata[15:0] = lin(`EXP_TEMP, `MANT_TEMP_FAULT);
            `CMD_VIN_OV_FAULT_THR: next_rdata[15:0] = lin(`EXP_VIN, `MANT_VIN_OV);
            `CMD_GOOD_ASSERT:      next_rdata[15:0] = `VOUT_GOOD_ON;
            `CMD_GOOD_NEGATE:      next_rdata[15:0] = `VOUT_GOOD_OFF;
            `CMD_TURN_ON_DELAY:    next_rdata[15:0] = turn_on_delay_time;
            `CMD_RISE_TIME:        next_rdata[15:0] = lin(`EXP_TIME, `MANT_RISE);
            `CMD_SUMMARY_WORD:     next_rdata[15:0] = summary;
            `CMD_OUTVOLT_BYTE:     begin next_rdata[7:0] = outvolt_fault_byte; next_rlen = 3'h1; end
            `CMD_OUTCURR_BYTE:     begin next_rdata[7:0] = outcurr_fault_byte; next_rlen = 3'h1; end
            `CMD_INPUT_BYTE:       begin next_rdata[7:0] = input_fault_byte; next_rlen = 3'h1; end
            `CMD_THERMAL_BYTE:     begin next_rdata[7:0] = thermal_fault_byte; next_rlen = 3'h1; end
            `CMD_COMMS_BYTE:       begin next_rdata[7:0] = comms_fault_byte; next_rlen = 3'h1; end
            `CMD_MEAS_VIN:         next_rdata[15:0] = meas_vin_in;
            `CMD_MEAS_VOUT:        next_rdata[15:0] = meas_vout_in;
            `CMD_MEAS_IOUT:        next_rdata[15:0] = meas_iout_in;
            `CMD_HOTSPOT_TEMP:     next_rdata[15:0] = meas_temp_in;
            `CMD_PROTOCOL_REV:     begin next_rdata[7:0] = PROTOCOL_REV; next_rlen = 3'h1; end
            `CMD_UNLOCK_KEY:       begin next_rdata = nonvolatile_unlock_key; next_rlen = 3'h4; end
            default:               next_rlen = 3'h0;
        endcase
    end

    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_rdata_out <= 32'h0000_0000;
            cmd_rlen_out  <= 3'h0;
            cmd_done_out  <= 1'b0;
        end else begin
            cmd_done_out <= cmd_valid_in;
            if (cmd_valid_in && !cmd_write_in) begin
                cmd_rdata_out <= next_rdata;
                cmd_rlen_out  <= next_rlen;
            end
        end
    end

    assign output_enable_out       = output_enable_command[`OUTPUT_ENABLE_BIT];
    assign flash_unlocked_out      = (nonvolatile_unlock_key == `UNLOCK_KEY_MATCH);
    assign temp_warn_threshold_out = temp_warn_threshold;
    assign turn_on_delay_time_out  = turn_on_delay_time;
    assign power_good_out          = good;

endmodule // power_module_cmd_regs

// *** verification/pmbus_host_model.sv ***
// Host-side requester that issues one-cycle command strobes at falling edges
module pmbus_host_model (
    input  logic        clk_in,
    output logic        valid_out,
    output logic        write_out,
    output logic [7:0]  code_out,
    output logic [2:0]  len_out,
    output logic [31:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        valid_out = 1'b0;
        {write_out, code_out, len_out, wdata_out} = 44'h000_0000_0000;
    end
    // Write, code, length and data are inverted once released, valid drops, so stale values never look valid
    task automatic send(input logic w, input logic [7:0] c, input logic [31:0] d,
                        input logic [2:0] l);
        @(negedge clk_in);
        valid_out = 1'b1;
        {write_out, code_out, len_out, wdata_out} = {w, c, l, d};
        @(negedge clk_in);
        valid_out = 1'b0;
        {write_out, code_out, len_out, wdata_out} = ~{w, c, l, d};
    endtask
endmodule // pmbus_host_model

// *** verification/power_module_cmd_regs_chk.sv ***
// Port-level assertions for the command register bank
module power_module_cmd_regs_chk (
    input logic        core_clk_in,
    input logic        arst_n_in,
    input logic        cmd_valid_in,
    input logic        cmd_write_in,
    input logic [7:0]  cmd_code_in,
    input logic [31:0] cmd_wdata_in,
    input logic [2:0]  cmd_rlen_out,
    input logic        cmd_done_out,
    input logic [15:0] meas_vout_in,
    input logic        output_enable_out,
    input logic        flash_unlocked_out,
    input logic [15:0] temp_warn_threshold_out,
    input logic [15:0] turn_on_delay_time_out,
    input logic        power_good_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    wire wr = cmd_valid_in && cmd_write_in;
    wire rd = cmd_valid_in && !cmd_write_in;
    a_done_follow: assert property (cmd_valid_in |=> cmd_done_out)
        else $error("no done after a request");
    a_word_len: assert property (rd && cmd_code_in == 8'h79 |=> cmd_rlen_out == 3'h2)
        else $error("summary read length wrong");
    a_byte_len: assert property (rd && cmd_code_in inside {[8'h7A:8'h7E]} |=> cmd_rlen_out == 3'h1)
        else $error("status byte read length wrong");
    a_enable_write: assert property (wr && cmd_code_in == 8'h01 |=> output_enable_out == $past(cmd_wdata_in[7]))
        else $error("enable bit not taken from write");
    a_unlock_match: assert property (wr && cmd_code_in == 8'hEC |=> flash_unlocked_out == ($past(cmd_wdata_in) == 32'h7E15_DC42))
        else $error("unlock state wrong after key write");
    a_warn_range: assert property (wr && cmd_code_in == 8'h51 && !(cmd_wdata_in[15:0] inside {[16'hF190:16'hF1E0]}) |=> $stable(temp_warn_threshold_out))
        else $error("out-of-range warning threshold taken");
    a_delay_range: assert property (wr && cmd_code_in == 8'h60 && !(cmd_wdata_in[15:0] inside {[16'hF82C:16'hF8A4]}) |=> $stable(turn_on_delay_time_out))
        else $error("out-of-range turn-on delay taken");
    a_good_on: assert property ((meas_vout_in >= 16'hB666) [*3] |-> power_good_out)
        else $error("power good not set at on level");
    a_good_off: assert property ((meas_vout_in <= 16'hB333) [*3] |-> !power_good_out)
        else $error("power good not cleared at off level");
endmodule // power_module_cmd_regs_chk
bind power_module_cmd_regs power_module_cmd_regs_chk chk_u (
    .core_clk_in, .arst_n_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_wdata_in,
    .cmd_rlen_out, .cmd_done_out, .meas_vout_in, .output_enable_out, .flash_unlocked_out,
    .temp_warn_threshold_out, .turn_on_delay_time_out, .power_good_out
);

// *** verification/tb_power_module_cmd_regs.sv ***
// Self-checking bench for the command register bank
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_power_module_cmd_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV_ID = 8'h11; // Arbitrary value
    localparam logic [7:0] RC[12] = '{8'h01, 8'h51, 8'h55, 8'h5E, 8'h5F, 8'h60, 8'h61,
        8'h98, 8'hEC, 8'h79, 8'h7E, 8'h00};
    localparam logic [31:0] RV[12] = '{32'h0000_0080, 32'h0000_F190, 32'h0000_E9F0,
        32'h0000_B666, 32'h0000_B333, 32'h0000_F82C, 32'h0000_F814, {24'h00_0000, REV_ID},
        32'hA5A5_A5A5, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    localparam logic [2:0] RL[12] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1,
        3'h4, 3'h2, 3'h1, 3'h0};
    localparam logic [7:0] EV[4] = '{8'hC0, 8'hA0, 8'h90, 8'hC0};
    localparam logic [15:0] PV[5] = '{16'hB333, 16'hB665, 16'hB666, 16'hB334, 16'hB333};
    localparam logic PE[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic        core_clk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        cmd_valid, cmd_write, cmd_done, out_on, output_enable, unlocked, good;
    logic [7:0]  cmd_code, ev;
    logic [2:0]  cmd_len, cmd_rlen;
    logic [31:0] cmd_wdata, cmd_rdata, v, seed = 32'h0000_152a;
    logic [15:0] meas_vin, meas_vout, meas_iout, meas_temp, warn_thr, delay_thr;
    logic [35:0] exp_q[$];
    logic [35:0] ent;
    int          n_fail = 0, num_checks = 0, cyc = 0;
    pmbus_host_model host_u (.clk_in(core_clk_in), .valid_out(cmd_valid), .write_out(cmd_write),
        .code_out(cmd_code), .len_out(cmd_len), .wdata_out(cmd_wdata));
    power_module_cmd_regs #(.PROTOCOL_REV(REV_ID)) dut_u (.core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
        .cmd_code_in(cmd_code), .cmd_len_in(cmd_len), .cmd_wdata_in(cmd_wdata),
        .cmd_rdata_out(cmd_rdata), .cmd_rlen_out(cmd_rlen), .cmd_done_out(cmd_done),
        .meas_vin_in(meas_vin), .meas_vout_in(meas_vout), .meas_iout_in(meas_iout),
        .meas_temp_in(meas_temp), .out_on_in(out_on), .vout_ov_fault_in(ev[0]),
        .vout_ov_warn_in(ev[1]), .iout_oc_fault_in(ev[2]), .iout_oc_warn_in(ev[3]),
        .vin_ov_fault_in(ev[4]), .vin_uv_fault_in(ev[5]), .temp_fault_in(ev[6]),
        .temp_warn_in(ev[7]), .output_enable_out(output_enable), .flash_unlocked_out(unlocked),
        .temp_warn_threshold_out(warn_thr), .turn_on_delay_time_out(delay_thr),
        .power_good_out(good));
    always #10 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic req(input logic w, input logic [7:0] c, input logic [31:0] d,
                       input logic [2:0] l);
        if (w && c == 8'h51 && d[15:0] >= 16'hF21C) return;
        exp_q.push_back({~w, l, d});
        host_u.send(w, c, d, l);
    endtask
    task automatic rd(input logic [7:0] c, input logic [31:0] e, input logic [2:0] l);
        req(1'b0, c, e, l);
    endtask
    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        req(1'b1, c, d, 3'h2);
    endtask
    task automatic settle();
        while (exp_q.size() != 0) @(negedge core_clk_in);
        @(negedge core_clk_in);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // -------------------------------------------------------------------------
    // Result watcher: pairs each done pulse with the oldest note
    // -------------------------------------------------------------------------
    always @(negedge core_clk_in) begin
        if (cmd_done === 1'b1) begin
            `CHK("pending note", 1'b1, exp_q.size() != 0)
            ent = exp_q.size() ? exp_q.pop_front() : 36'h0_0000_0000;
            if (ent[35]) begin
                `CHK("read data", ent[31:0], cmd_rdata)
                `CHK("read length", ent[34:32], cmd_rlen)
            end
        end
    end
    initial begin
        {meas_vin, meas_iout, meas_temp, ev, out_on, meas_vout} = {56'h0, 1'b1, 16'hB700};
        repeat (20) @(negedge core_clk_in);
        arst_n_in = 1'b1;
        foreach (RC[i]) rd(RC[i], RV[i], RL[i]);
        settle();
        `CHK("enable", 1'b1, output_enable)
        $display("test reset_values done");
        repeat (4) begin
            v = rnd();
            {meas_vin, meas_iout, meas_temp} = {v, v[15:0] ^ 16'h5A5A};
            meas_vout = 16'hB700 | v[7:0];
            rd(8'h88, {16'h0000, meas_vin}, 3'h2);
            rd(8'h8B, {16'h0000, meas_vout}, 3'h2);
            rd(8'h8C, {16'h0000, meas_iout}, 3'h2);
            rd(8'h8D, {16'h0000, meas_temp}, 3'h2);
        end
        $display("test telemetry done");
        wr(8'h51, 32'h0000_F1E0);
        wr(8'h51, 32'h0000_F18C);
        wr(8'h51, 32'h0000_E9F0);
        wr(8'h60, 32'h0000_F8A4);
        wr(8'h60, 32'h0000_F8A6);
        rd(8'h7E, 32'h0000_0040, 3'h1);
        wr(8'h55, 32'h0000_0000);
        wr(8'h4A, 32'h0000_0000);
        rd(8'h55, 32'h0000_E9F0, 3'h2);
        rd(8'h4F, 32'h0000_F21C, 3'h2);
        rd(8'h7E, 32'h0000_00C0, 3'h1);
        rd(8'h79, 32'h0000_0002, 3'h2);
        settle();
        `CHK("warn threshold", 16'hF1E0, warn_thr)
        `CHK("turn-on delay", 16'hF8A4, delay_thr)
        $display("test limits done");
        {out_on, meas_vout} = {1'b0, 16'hB000};
        repeat (3) @(negedge core_clk_in);
        ev = 8'hFF;
        @(negedge core_clk_in);
        ev = 8'h00;
        for (int i = 0; i < 4; i++) rd(8'h7A + i, {24'h00_0000, EV[i]}, 3'h1);
        rd(8'h79, 32'h0000_E87E, 3'h2);
        {out_on, meas_vout} = {1'b1, 16'hB700};
        wr(8'h03, 32'h0000_0000);
        for (int i = 0; i < 5; i++) rd(8'h79 + i, 32'h0000_0000, i ? 3'h1 : 3'h2);
        $display("test faults done");
        wr(8'h01, 32'h0000_007F);
        rd(8'h01, 32'h0000_0000, 3'h1);
        settle();
        `CHK("enable", 1'b0, output_enable)
        wr(8'hEC, 32'h7E15_DC42);
        rd(8'hEC, 32'h7E15_DC42, 3'h4);
        settle();
        `CHK("unlock", 1'b1, unlocked)
        wr(8'hEC, 32'h7E15_DC43);
        settle();
        `CHK("unlock", 1'b0, unlocked)
        $display("test enable_key done");
        foreach (PV[i]) begin
            meas_vout = PV[i];
            repeat (4) @(negedge core_clk_in);
            `CHK("power good", PE[i], good)
        end
        $display("test power_good done");
        arst_n_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        arst_n_in = 1'b1;
        rd(8'h01, 32'h0000_0080, 3'h1);
        rd(8'hEC, 32'hA5A5_A5A5, 3'h4);
        settle();
        $display("test second_reset done");
        complete_run();
    end
endmodule // tb_power_module_cmd_regs
